// file: design/pmcc_pkg.sv
// Shared constants, types and bus carriers for the clock management block.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
`default_nettype none

package pmcc_pkg;

    // =========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_SCER = 8'h00;
    localparam logic [7:0] OFF_SCDR = 8'h04;
    localparam logic [7:0] OFF_SCSR = 8'h08;
    localparam logic [7:0] OFF_PCER = 8'h10;
    localparam logic [7:0] OFF_PCDR = 8'h14;
    localparam logic [7:0] OFF_PCSR = 8'h18;
    localparam logic [7:0] OFF_PLL1 = 8'h28;
    localparam logic [7:0] OFF_PLL2 = 8'h2c;
    localparam logic [7:0] OFF_MCKR = 8'h30;
    localparam logic [7:0] OFF_IER = 8'h60;
    localparam logic [7:0] OFF_IDR = 8'h64;
    localparam logic [7:0] OFF_SR = 8'h68;
    localparam logic [7:0] OFF_IMR = 8'h6c;

    // =========================================================
    // Field positions and widths
    localparam int PLL_DIV_LSB = 0;
    localparam int PLL_DIV_W = 8;
    localparam int PLL_CNT_LSB = 8;
    localparam int PLL_CNT_W = 6;
    localparam int PLL_MUL_LSB = 16;
    localparam int PLL_MUL_W = 11;
    localparam int PLL_HALF_BIT = 28;
    localparam logic [31:0] PLL_RW_MASK = 32'h17ff_3fff;
    localparam int MCKR_W = 10;
    localparam int CSS_LSB = 0;
    localparam int MASTER_PRESCALE_LSB = 2;
    localparam int PROCESSOR_RATIO_LSB = 8;
    localparam logic [9:0] MCKR_RW_MASK = 10'h31f;
    localparam int SC_PROC = 0;
    localparam int SC_UDP = 1;
    localparam int SC_AUTO = 2;
    localparam int SC_UHP = 4;
    localparam int SR_LOCK1 = 1;
    localparam int SR_LOCK2 = 2;
    localparam int SR_MRDY = 3;
    localparam logic [3:0] SR_MASK = 4'he;

    // =========================================================
    // Reset values and timing counts
    localparam logic [31:0] PLL_RST = 32'h0000_3f00;
    localparam logic [9:0] MCKR_RST = 10'h000;
    localparam logic [31:0] PCSR_RST = 32'h0000_0000;
    localparam logic [2:0] MASTER_PRESCALE_MAX = 3'h6;
    localparam logic [5:0] MCK_SETTLE_SLOW = 6'h04;

    // =========================================================
    // Enumerations
    typedef enum logic [1:0] {
        PC_ON = 2'b00,
        PC_DRAIN = 2'b01,
        PC_OFF = 2'b10
    } pmcc_pc_t;

    typedef enum logic [1:0] {
        SRC_SLOW = 2'b00,
        SRC_MAIN = 2'b01,
        SRC_PLL1 = 2'b10,
        SRC_PLL2 = 2'b11
    } pmcc_src_t;

    // =========================================================
    // Wishbone carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pmcc_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pmcc_wb_rsp_t;

endpackage : pmcc_pkg

`default_nettype wire

// file: design/pmcc_div.sv
// Tick divider: passes one input tick out of every div_i ticks.
// Assumes tick_i is a one-cycle pulse synchronous to clk_i.
`default_nettype none

module pmcc_div #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic [W-1:0] div_i,
    output logic tick_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } pmcc_div_st_t;

    pmcc_div_st_t st_q;
    pmcc_div_st_t st_d;

    if (W < 1 || W > 16) begin : g_bad_w
        $error("pmcc_div: W out of range");
    end

    // =========================================================
    // Counter
    always_comb
    begin
        st_d = st_q;
        st_d.tick = 1'b0;
        // Zero divisor never ticks: output held low
        if (tick_i && div_i != '0)
        begin
            if (st_q.cnt >= div_i - W'(1))
            begin
                st_d.cnt = '0;
                st_d.tick = 1'b1;
            end
            else
            begin
                st_d.cnt = st_q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_q <= '0;
        else if (ce_i)
            st_q <= st_d;
    end

    assign tick_o = st_q.tick;

endmodule : pmcc_div

`default_nettype wire

// file: design/pmcc_lock.sv
// Lock/settle counter clocked by slow-clock ticks; flag rises when it runs out.
// Assumes tick_i is a one-cycle pulse per slow clock period.
`default_nettype none

module pmcc_lock #(
    parameter int W = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic restart_i,
    input wire logic [W-1:0] count_i,
    output logic flag_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic flag;
    } pmcc_lock_st_t;

    pmcc_lock_st_t st_q;
    pmcc_lock_st_t st_d;

    if (W < 1 || W > 16) begin : g_bad_w
        $error("pmcc_lock: W out of range");
    end

    // =========================================================
    // Countdown
    always_comb
    begin
        st_d = st_q;
        // Restart beats a same-cycle expiry: the old lock is stale
        if (restart_i)
        begin
            st_d.cnt = count_i;
            st_d.flag = 1'b0;
        end
        else if (tick_i && !st_q.flag)
        begin
            if (st_q.cnt <= W'(1))
            begin
                st_d.cnt = '0;
                st_d.flag = 1'b1;
            end
            else
            begin
                st_d.cnt = st_q.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_q <= '0;
        else if (ce_i)
            st_q <= st_d;
    end

    assign flag_o = st_q.flag;

endmodule : pmcc_lock

`default_nettype wire

// file: design/pmcc_top.sv
// Clock management: input dividers, PLL control and lock, master clock
// selection, processor idle gating, peripheral and USB clock gating.
// Assumes all inputs are synchronous to clk_i; main and PLL clocks arrive as tick pulses, slow clock as a level.
//
// Behaviour
// - Each input divider divides main clock by its field, 1 to 255.
// - Divider field zero holds divider and PLL output low; fields reset zero.
// - PLL output is source times multiplier plus one over divider.
// - Multiplier zero disables the PLL; nonzero enables it again.
// - Re-enable or parameter change clears lock flag and reloads lock count.
// - Lock counter decrements per slow tick; at zero sets lock flag.
// - Halve bit divides second PLL by two; software then programs 96 MHz.
// - Master source is slow, main, first PLL or second PLL clock.
// - Prescale field divides selected source by power of two, 1 to 64.
// - Processor ratio sets master clock as processor clock over 1 to 4.
// - Master clock register write clears ready flag until clock settles.
// - Processor clock enabled/disabled by system writes, shown in status.
// - Processor clock on after reset; interrupt or reset wakes it.
// - Processor clock stops only after current instruction completes.
// - Peripheral clocks enabled/disabled by bit writes, shown in status.
// - Peripheral clock stops at once, resumes later; all off after reset.
// - Peripheral bit position equals the peripheral identifier.
// - Device port bit starts and stops the USB device clock.
// - Suspend stops device clock; auto bit also stops its master clock.
// - Host port bit starts and stops the USB host clock.
// - Slow clock always runs and clocks the lock counters.
//
// The address map and the Wishbone register port were decided locally.
`default_nettype none

module pmcc_top #(
    parameter int DEV_PORT_ID = 11
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire pmcc_pkg::pmcc_wb_req_t wb_req_i,
    output pmcc_pkg::pmcc_wb_rsp_t wb_rsp_o,
    input wire logic slow_clk_i,
    input wire logic main_tick_i,
    input wire logic pll1_tick_i,
    input wire logic pll2_tick_i,
    input wire logic irq_wake_i,
    input wire logic instr_done_i,
    input wire logic usb_suspend_i,
    output logic div1_tick_o,
    output logic div2_tick_o,
    output logic [10:0] pll1_mul_o,
    output logic [10:0] pll2_mul_o,
    output logic [7:0] pll1_div_o,
    output logic [7:0] pll2_div_o,
    output logic proc_clk_en_o,
    output logic master_clk_en_o,
    output logic [31:0] periph_clk_en_o,
    output logic usb_dev_clk_en_o,
    output logic usb_host_clk_en_o,
    output logic irq_o
);
    import pmcc_pkg::*;

    if (DEV_PORT_ID < 0 || DEV_PORT_ID > 31) begin : g_bad_id
        $error("pmcc_top: DEV_PORT_ID out of range");
    end

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [31:0] pll1;
        logic [31:0] pll2;
        logic [9:0] mckr;
        logic [31:0] pcsr;
        pmcc_pc_t pc;
        logic device_port_clock_bit;
        logic host_port_clock_bit;
        logic autod;
        logic [3:0] imr;
        logic irq;
        logic slow;
        logic half;
        logic [1:0] ratio_cnt;
        logic proc;
        logic master_clock;
        logic [31:0] periph;
        logic udclk;
        logic uhclk;
    } pmcc_top_st_t;

    localparam pmcc_top_st_t ST_RST = '{
        pll1: PLL_RST, pll2: PLL_RST, mckr: MCKR_RST, pcsr: PCSR_RST,
        pc: PC_ON, default: '0};

    pmcc_top_st_t st_q;
    pmcc_top_st_t st_d;

    // =========================================================
    // Bus decode helpers
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : byte_mask

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    logic req;
    logic wr;
    logic [31:0] bm;
    logic [31:0] wd;
    logic wr_scer;
    logic wr_scdr;
    logic wr_pcer;
    logic wr_pcdr;
    logic wr_pll1;
    logic wr_pll2;
    logic wr_mckr;
    logic wr_ier;
    logic wr_idr;

    assign req = wb_req_i.cyc && wb_req_i.stb && !st_q.ack;
    assign wr = req && wb_req_i.we;
    assign bm = byte_mask(wb_req_i.sel);
    assign wd = wb_req_i.dat & bm;
    assign wr_scer = wr && hit(wb_req_i.adr, OFF_SCER);
    assign wr_scdr = wr && hit(wb_req_i.adr, OFF_SCDR);
    assign wr_pcer = wr && hit(wb_req_i.adr, OFF_PCER);
    assign wr_pcdr = wr && hit(wb_req_i.adr, OFF_PCDR);
    assign wr_pll1 = wr && hit(wb_req_i.adr, OFF_PLL1);
    assign wr_pll2 = wr && hit(wb_req_i.adr, OFF_PLL2);
    assign wr_mckr = wr && hit(wb_req_i.adr, OFF_MCKR);
    assign wr_ier = wr && hit(wb_req_i.adr, OFF_IER);
    assign wr_idr = wr && hit(wb_req_i.adr, OFF_IDR);

    // =========================================================
    // Clock sources
    logic slow_tick;
    logic pll1_on;
    logic pll2_on;
    logic pll1_g;
    logic pll2_g;
    logic pll2_out;
    logic src_tick;
    logic master_prescale_tick;
    logic [2:0] master_prescale;
    logic lock1;
    logic lock2;
    logic mrdy;
    logic [31:0] pll1_new;
    logic [31:0] pll2_new;
    logic restart1;
    logic restart2;
    logic [3:0] sr;

    // Inputs are synchronous, so a single flop is enough for the edge
    assign slow_tick = slow_clk_i && !st_q.slow;
    assign pll1_on = st_q.pll1[PLL_DIV_LSB +: PLL_DIV_W] != '0 && st_q.pll1[PLL_MUL_LSB +: PLL_MUL_W] != '0;
    assign pll2_on = st_q.pll2[PLL_DIV_LSB +: PLL_DIV_W] != '0 && st_q.pll2[PLL_MUL_LSB +: PLL_MUL_W] != '0;
    assign pll1_g = pll1_tick_i && pll1_on;
    assign pll2_g = pll2_tick_i && pll2_on;
    assign pll2_out = st_q.pll2[PLL_HALF_BIT] ? (pll2_g && st_q.half) : pll2_g;

    always_comb
    begin
        case (pmcc_src_t'(st_q.mckr[CSS_LSB +: 2]))
            SRC_SLOW: src_tick = slow_tick;
            SRC_MAIN: src_tick = main_tick_i;
            SRC_PLL1: src_tick = pll1_g;
            SRC_PLL2: src_tick = pll2_out;
            default: src_tick = 1'b0;
        endcase
    end

    // Reserved prescale code 7 is treated as the largest ratio
    assign master_prescale = (st_q.mckr[MASTER_PRESCALE_LSB +: 3] > MASTER_PRESCALE_MAX) ? MASTER_PRESCALE_MAX : st_q.mckr[MASTER_PRESCALE_LSB +: 3];

    pmcc_div #(.W(PLL_DIV_W)) u_div1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(main_tick_i),
        .div_i(st_q.pll1[PLL_DIV_LSB +: PLL_DIV_W]),
        .tick_o(div1_tick_o)
    );

    pmcc_div #(.W(PLL_DIV_W)) u_div2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(main_tick_i),
        .div_i(st_q.pll2[PLL_DIV_LSB +: PLL_DIV_W]),
        .tick_o(div2_tick_o)
    );

    pmcc_div #(.W(7)) u_master_prescale (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(src_tick),
        .div_i(7'h01 << master_prescale),
        .tick_o(master_prescale_tick)
    );

    // =========================================================
    // Lock and settle counters
    always_comb
    begin
        pll1_new = st_q.pll1;
        pll2_new = st_q.pll2;
        if (wr_pll1)
            pll1_new = ((st_q.pll1 & ~bm) | wd) & PLL_RW_MASK;
        if (wr_pll2)
            pll2_new = ((st_q.pll2 & ~bm) | wd) & PLL_RW_MASK;
    end

    // A disabled PLL keeps its counter loaded so it starts fresh
    assign restart1 = (pll1_new != st_q.pll1) || !pll1_on;
    assign restart2 = (pll2_new != st_q.pll2) || !pll2_on;

    pmcc_lock #(.W(PLL_CNT_W)) u_lock1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(slow_tick),
        .restart_i(restart1),
        .count_i(pll1_new[PLL_CNT_LSB +: PLL_CNT_W]),
        .flag_o(lock1)
    );

    pmcc_lock #(.W(PLL_CNT_W)) u_lock2 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(slow_tick),
        .restart_i(restart2),
        .count_i(pll2_new[PLL_CNT_LSB +: PLL_CNT_W]),
        .flag_o(lock2)
    );

    pmcc_lock #(.W(PLL_CNT_W)) u_mrdy (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .tick_i(slow_tick),
        .restart_i(wr_mckr),
        .count_i(MCK_SETTLE_SLOW),
        .flag_o(mrdy)
    );

    assign sr = {mrdy, lock2, lock1, 1'b0};

    // =========================================================
    // Next state
    always_comb
    begin
        st_d = st_q;
        st_d.ack = req; // One-cycle ack, dropped in the next cycle
        st_d.slow = slow_clk_i;
        st_d.pll1 = pll1_new;
        st_d.pll2 = pll2_new;
        if (wr_mckr)
            st_d.mckr = ((st_q.mckr & ~bm[9:0]) | wd[9:0]) & MCKR_RW_MASK;
        if (pll2_g)
            st_d.half = !st_q.half;

        // Processor ratio counter
        st_d.master_clock = 1'b0;
        if (master_prescale_tick)
        begin
            if (st_q.ratio_cnt >= st_q.mckr[PROCESSOR_RATIO_LSB +: 2])
            begin
                st_d.ratio_cnt = 2'h0;
                st_d.master_clock = 1'b1;
            end
            else
            begin
                st_d.ratio_cnt = st_q.ratio_cnt + 2'h1;
            end
        end

        // Processor idle gating
        case (st_q.pc)
            PC_ON: if (wr_scdr && wd[SC_PROC]) st_d.pc = PC_DRAIN;
            PC_DRAIN: if (instr_done_i) st_d.pc = PC_OFF;
            PC_OFF: if (irq_wake_i) st_d.pc = PC_ON;
            default: st_d.pc = PC_ON;
        endcase
        if ((wr_scer && wd[SC_PROC]) || (st_q.pc != PC_ON && irq_wake_i))
            st_d.pc = PC_ON;
        st_d.proc = master_prescale_tick && st_q.pc != PC_OFF;

        // USB clocks; enable writes win over suspend
        if (usb_suspend_i)
            st_d.device_port_clock_bit = 1'b0;
        if (wr_scdr)
        begin
            st_d.device_port_clock_bit = st_d.device_port_clock_bit && !wd[SC_UDP];
            st_d.host_port_clock_bit = st_q.host_port_clock_bit && !wd[SC_UHP];
            st_d.autod = st_q.autod && !wd[SC_AUTO];
        end
        if (wr_scer)
        begin
            st_d.device_port_clock_bit = st_d.device_port_clock_bit || wd[SC_UDP];
            st_d.host_port_clock_bit = st_d.host_port_clock_bit || wd[SC_UHP];
            st_d.autod = st_d.autod || wd[SC_AUTO];
        end
        st_d.udclk = pll2_out && st_q.device_port_clock_bit;
        st_d.uhclk = pll2_out && st_q.host_port_clock_bit;

        // Peripheral clocks, bit n is peripheral n
        if (usb_suspend_i && st_q.autod)
            st_d.pcsr[DEV_PORT_ID] = 1'b0;
        if (wr_pcdr)
            st_d.pcsr = st_d.pcsr & ~wd;
        if (wr_pcer)
            st_d.pcsr = st_d.pcsr | wd;
        // Gating the tick freezes the peripheral in place
        st_d.periph = {32{st_q.master_clock}} & st_q.pcsr;

        // Interrupt mask and output
        if (wr_idr)
            st_d.imr = st_q.imr & ~wd[3:0];
        if (wr_ier)
            st_d.imr = (st_d.imr | wd[3:0]) & SR_MASK;
        st_d.irq = |(sr & st_q.imr);

        // Read data; unmapped offsets read zero
        st_d.rdat = 32'h0000_0000;
        if (req && !wb_req_i.we)
        begin
            case (wb_req_i.adr[7:2])
                OFF_SCSR[7:2]: st_d.rdat = 32'(st_q.pc != PC_OFF) | (32'(st_q.device_port_clock_bit) << SC_UDP)
                    | (32'(st_q.autod) << SC_AUTO) | (32'(st_q.host_port_clock_bit) << SC_UHP);
                OFF_PCSR[7:2]: st_d.rdat = st_q.pcsr;
                OFF_PLL1[7:2]: st_d.rdat = st_q.pll1;
                OFF_PLL2[7:2]: st_d.rdat = st_q.pll2;
                OFF_MCKR[7:2]: st_d.rdat = 32'(st_q.mckr);
                OFF_SR[7:2]: st_d.rdat = 32'(sr);
                OFF_IMR[7:2]: st_d.rdat = 32'(st_q.imr);
                default: st_d.rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st_q <= ST_RST;
        else if (ce_i)
            st_q <= st_d;
    end

    // =========================================================
    // Outputs
    assign wb_rsp_o.ack = st_q.ack;
    assign wb_rsp_o.dat = st_q.rdat;
    assign pll1_mul_o = st_q.pll1[PLL_MUL_LSB +: PLL_MUL_W];
    assign pll2_mul_o = st_q.pll2[PLL_MUL_LSB +: PLL_MUL_W];
    assign pll1_div_o = st_q.pll1[PLL_DIV_LSB +: PLL_DIV_W];
    assign pll2_div_o = st_q.pll2[PLL_DIV_LSB +: PLL_DIV_W];
    assign proc_clk_en_o = st_q.proc;
    assign master_clk_en_o = st_q.master_clock;
    assign periph_clk_en_o = st_q.periph;
    assign usb_dev_clk_en_o = st_q.udclk;
    assign usb_host_clk_en_o = st_q.uhclk;
    assign irq_o = st_q.irq;

    // =========================================================
    // Checks
    sequence s_drain_req;
        ce_i && st_q.pc == PC_ON && wr_scdr && wd[SC_PROC] && !wr_scer && !irq_wake_i;
    endsequence

    sequence s_drain_hold;
        ce_i && st_q.pc == PC_DRAIN && !instr_done_i && !irq_wake_i && !wr_scer;
    endsequence

    property p_drain;
        @(posedge clk_i) disable iff (rst_i) s_drain_req |=> st_q.pc == PC_DRAIN;
    endproperty
    a_drain: assert property (p_drain) else $error("idle request did not drain");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i) s_drain_hold |=> st_q.pc != PC_OFF;
    endproperty
    a_hold: assert property (p_hold) else $error("clock stopped mid instruction");

    property p_wake;
        @(posedge clk_i) disable iff (rst_i) ce_i && st_q.pc == PC_OFF && irq_wake_i |=> st_q.pc == PC_ON;
    endproperty
    a_wake: assert property (p_wake) else $error("interrupt did not wake processor");

    property p_reset_on;
        @(posedge clk_i) $fell(rst_i) |-> st_q.pc == PC_ON && st_q.pcsr == '0;
    endproperty
    a_reset_on: assert property (p_reset_on) else $error("bad clock state after reset");

    property p_pcer;
        @(posedge clk_i) disable iff (rst_i) ce_i && wr_pcer |=> (st_q.pcsr & $past(wd)) == $past(wd);
    endproperty
    a_pcer: assert property (p_pcer) else $error("peripheral enable lost");

    property p_pcdr;
        @(posedge clk_i) disable iff (rst_i) ce_i && wr_pcdr && !wr_pcer |=> (st_q.pcsr & $past(wd)) == '0;
    endproperty
    a_pcdr: assert property (p_pcdr) else $error("peripheral disable lost");

    property p_mrdy;
        @(posedge clk_i) disable iff (rst_i) ce_i && wr_mckr |=> !mrdy ##0 !mrdy [*2];
    endproperty
    a_mrdy: assert property (p_mrdy) else $error("ready flag not cleared");

    property p_lock_clear;
        @(posedge clk_i) disable iff (rst_i) ce_i && restart1 |=> !lock1;
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("lock flag survived restart");

    property p_suspend;
        @(posedge clk_i) disable iff (rst_i) ce_i && usb_suspend_i && !(wr_scer && wd[SC_UDP]) |=> !st_q.device_port_clock_bit;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend kept device clock");

    // Divider output is registered, so it follows the zero field one cycle later
    property p_gate;
        @(posedge clk_i) disable iff (rst_i)
            ce_i && st_q.pll1[PLL_DIV_LSB +: PLL_DIV_W] == '0 |-> !pll1_g ##1 !div1_tick_o;
    endproperty
    a_gate: assert property (p_gate) else $error("zero divider produced output");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i) ce_i ##1 ce_i |-> irq_o == $past(|(sr & st_q.imr));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output wrong");

endmodule : pmcc_top

`default_nettype wire

// file: tb/pmcc_tb.sv
// Self-checking bench for the clock management block.
// Assumes the package and design files are compiled first.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pmcc_pkg::*;

    // ==========================================================
    // Stimulus signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic slow_clk_i = 1'b0;
    logic main_tick_i = 1'b0;
    logic irq_wake_i = 1'b0;
    logic instr_done_i = 1'b0;
    logic usb_suspend_i = 1'b0;
    logic [2:0] slow_div_q = 3'h0;
    pmcc_wb_req_t req = '0;
    pmcc_wb_rsp_t rsp;
    logic div1, div2, proc_en, mck_en, dev_en, host_en, irq;
    logic [10:0] mul1, mul2;
    logic [7:0] dv1, dv2;
    logic [31:0] pen;
    logic [31:0] rd;
    int failures = 0;
    int checks = 0;

    pmcc_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .slow_clk_i(slow_clk_i), .main_tick_i(main_tick_i), .pll1_tick_i(main_tick_i),
        .pll2_tick_i(main_tick_i), .irq_wake_i(irq_wake_i), .instr_done_i(instr_done_i),
        .usb_suspend_i(usb_suspend_i), .div1_tick_o(div1), .div2_tick_o(div2), .pll1_mul_o(mul1),
        .pll2_mul_o(mul2), .pll1_div_o(dv1), .pll2_div_o(dv2), .proc_clk_en_o(proc_en),
        .master_clk_en_o(mck_en), .periph_clk_en_o(pen), .usb_dev_clk_en_o(dev_en),
        .usb_host_clk_en_o(host_en), .irq_o(irq));

    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Slow clock runs free at one eighth of clk; main tick every cycle
    always @(posedge clk_i)
    begin
        slow_div_q <= slow_div_q + 3'h1;
        slow_clk_i <= slow_div_q[2];
        main_tick_i <= ~rst_i;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        rd = rsp.dat;
        chk("ack", {31'h0, rsp.ack}, 32'h1);
        req <= '0;
        @(posedge clk_i);
    endtask : bus

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string nm);
        bus(1'b0, adr, 32'h0);
        chk(nm, rd, exp);
    endtask : rdchk

    // Selector: 0 div2, 1 host, 2 device, 3 master, 4 processor
    task automatic count_ticks(input string nm, input int sel, input int n, input int exp);
        int c;
        logic [4:0] v;
        c = 0;
        repeat (n)
        begin
            @(posedge clk_i);
            v = {proc_en, mck_en, dev_en, host_en, div2};
            c += int'(v[sel] === 1'b1);
        end
        chk(nm, 32'(c), 32'(exp));
    endtask : count_ticks

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rdchk(OFF_SCSR, 32'h1, "sys status");
        rdchk(OFF_PCSR, PCSR_RST, "periph status");
        rdchk(OFF_PLL1, PLL_RST, "pll1 reg");
        rdchk(8'h20, 32'h0, "unmapped");
    endtask : t_reset

    task automatic t_periph();
        bus(1'b1, OFF_PCER, 32'h0000_0808);
        rdchk(OFF_PCSR, 32'h0000_0808, "periph on");
        bus(1'b1, OFF_PCDR, 32'h0000_0008);
        rdchk(OFF_PCSR, 32'h0000_0800, "periph off");
    endtask : t_periph

    task automatic t_usb();
        bus(1'b1, OFF_SCER, 32'h0000_0016);
        rdchk(OFF_SCSR, 32'h17, "usb on");
        usb_suspend_i <= 1'b1;
        @(posedge clk_i);
        usb_suspend_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rdchk(OFF_SCSR, 32'h15, "suspend");
        rdchk(OFF_PCSR, 32'h0, "suspend mck");
        bus(1'b1, OFF_SCDR, 32'h0000_0014);
        rdchk(OFF_SCSR, 32'h01, "usb off");
    endtask : t_usb

    task automatic t_lock();
        bus(1'b1, OFF_PLL1, 32'h0005_0301);
        bus(1'b1, OFF_MCKR, 32'h0000_0001);
        rdchk(OFF_SR, 32'h0, "flags clear");
        bus(1'b1, OFF_IER, 32'h0000_000a);
        chk("irq low", {31'h0, irq}, 32'h0);
        repeat (60) @(posedge clk_i);
        rdchk(OFF_SR, 32'h0a, "flags set");
        chk("irq high", {31'h0, irq}, 32'h1);
        rdchk(OFF_MCKR, 32'h1, "master reg");
        chk("pll1 mul", {21'h0, mul1}, 32'h5);
        chk("pll1 div", {24'h0, dv1}, 32'h1);
        chk("div1 tick", {31'h0, div1}, 32'h1);
    endtask : t_lock

    task automatic t_div();
        bus(1'b1, OFF_PLL2, 32'h0001_0003);
        repeat (4) @(posedge clk_i);
        count_ticks("div2 ticks", 0, 30, 10);
        bus(1'b1, OFF_PLL2, 32'h0001_0000);
        repeat (4) @(posedge clk_i);
        count_ticks("div2 off", 0, 30, 0);
    endtask : t_div

    task automatic t_half();
        bus(1'b1, OFF_PLL2, 32'h1001_0001);
        bus(1'b1, OFF_SCER, 32'h0000_0012);
        chk("pll2 div", {24'h0, dv2}, 32'h1);
        count_ticks("host", 1, 30, 15);
        count_ticks("device", 2, 30, 15);
        bus(1'b1, OFF_SCDR, 32'h0000_0012);
        count_ticks("host off", 1, 30, 0);
    endtask : t_half

    task automatic t_idle();
        bus(1'b1, OFF_SCDR, 32'h1);
        instr_done_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rdchk(OFF_SCSR, 32'h0, "idle");
        chk("proc off", {31'h0, proc_en}, 32'h0);
        irq_wake_i <= 1'b1;
        @(posedge clk_i);
        irq_wake_i <= 1'b0;
        instr_done_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rdchk(OFF_SCSR, 32'h1, "wake");
        chk("proc on", {31'h0, proc_en}, 32'h1);
        chk("master on", {31'h0, mck_en}, 32'h1);
    endtask : t_idle

    // Request held while the enable is low must wait for it
    task automatic t_freeze();
        ce_i <= 1'b0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1, adr: OFF_PCER, sel: 4'hf, dat: 32'h0000_0001};
        repeat (4) @(posedge clk_i);
        chk("frozen ack", {31'h0, rsp.ack}, 32'h0);
        ce_i <= 1'b1;
        bus(1'b1, OFF_PCER, 32'h0000_0001);
        rdchk(OFF_PCSR, 32'h0000_0001, "periph ce");
        chk("periph clk", pen, 32'h0000_0001);
    endtask : t_freeze

    task automatic t_master();
        bus(1'b1, OFF_MCKR, 32'h0000_0105);
        repeat (4) @(posedge clk_i);
        count_ticks("master", 3, 40, 10);
        count_ticks("proc", 4, 40, 20);
    endtask : t_master

    task automatic close_out();
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_periph();
        t_usb();
        t_lock();
        t_div();
        t_half();
        t_idle();
        t_freeze();
        t_master();
        close_out();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #50000;
        failures++;
        close_out();
    end
endmodule : testbench

`default_nettype wire
